// [design/backlight_dimming_control_status_regs.sv]
`timescale 1ns/10ps
// Behaviour
// - control bit 2: absolute or percentage
// - control bit 1: pulse or bus brightness
// - control bit 0 switches LED outputs
// - source select 1 uses pulse duty
// - select 0: brightness alone or product
// - status read-only, top bits zero
// - status bit 0 ORs non-LED faults
// - status bit 5: two+ channels faulted
// - status bit 4: one channel faulted
// - status bit 3 shows backlight state
// - status bit 2 shows input overcurrent
// - status bit 1 shows thermal shutdown
// - over-temperature holds everything off until release
// - identification read-only, top bit one
// - identification bits 6:3 maker code
// - identification bits 2:0 revision
// - turn on within 10 ms, off immediately
// - control bits 7:3 read zero
// - brightness writes ignored in pulse mode
// - answer at target address 0101100
module backlight_dimming_control_status_regs
	import backlight_pkg::*;
#(
	parameter int         CHANNELS        = 8,          // LED strings watched for faults
	parameter int         ON_DELAY_CYCLES = ON_CYCLES,  // soft start before the backlight counts as on
	parameter int         WIN_BITS        = 20,
	parameter int         DIM_DIV         = 391,
	parameter logic [3:0] MAKER_CODE      = 4'ha,       // arbitrary value
	parameter logic [2:0] REVISION        = 3'h2        // arbitrary value
) (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                link_clk,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire logic                dimming_pulse_input,
	input  wire logic                over_temp,
	input  wire logic                temp_release,
	input  wire logic                input_overcurrent,
	input  wire logic                converter_fault,
	input  wire logic [CHANNELS-1:0] led_channel_fault,
	output logic                     controller_enable,
	output logic                     led_enable,
	output logic                     internal_dimming_pulse,
	output logic [7:0]               duty_level
);
	// ==========================================================
	// elaboration checks
	initial begin
		if (CHANNELS < 1 || CHANNELS > 255)
			$error("backlight regs: CHANNELS out of range");
		if (ON_DELAY_CYCLES < 1 || ON_DELAY_CYCLES >= (1 << 20))
			$error("backlight regs: ON_DELAY_CYCLES must fit 20 bits");
	end

	localparam int NPIN = CHANNELS + PIN_CHAN0;
	localparam logic [19:0] ON_LAST = 20'(ON_DELAY_CYCLES - 1);

	// ==========================================================
	// helpers
	// number of faulted strings
	function automatic logic [7:0] count_faults(input logic [CHANNELS-1:0] v);
		logic [7:0] n;
		n = 8'h0;
		for (int i = 0; i < CHANNELS; i++)
			n = n + {7'h0, v[i]};
		return n;
	endfunction : count_faults

	// bus value scaled by pulse duty, 0xff * 0xff stays at 0xff
	function automatic logic [7:0] scale_duty(input logic [7:0] a, input logic [7:0] b);
		logic [16:0] p;
		// widen before the product so the upper byte is not lost
		p = {1'h0, {8'h0, a} * {8'h0, b}} + {9'h0, a} + {9'h0, b};
		return p[15:8];
	endfunction : scale_duty

	// ==========================================================
	// state
	typedef struct packed {
		logic [NPIN-1:0] pin_s1, pin_s2;   // fault pin synchroniser
		logic            req_s1, req_s2, req_s3;
		logic            ack_tgl;
		logic [7:0]      rdata;
		logic [7:0]      bright;           // brightness_level
		logic [2:0]      ctrl;             // control bits 2:0
		logic            thermal;          // thermal_fault_flag, latched
		logic            bl_state;         // backlight_state
		logic            ctrl_en;
		logic [19:0]     on_cnt;
		logic [7:0]      duty;
	} state_type;
	state_type q, d;

	reg_xfer_if xfer ();                 // link to register bank carrier
	logic [7:0] measured;                // pulse input duty from the duty unit
	logic [7:0] status_w;                // fault/status as read
	logic [7:0] ident_w;                 // identification as read
	logic [7:0] nfault;                  // faulted string count
	logic       ovc, conv, req_ev;

	// ==========================================================
	// link engine on its own clock
	smbus_link_engine u_link (
		.link_clk (link_clk),
		.rstn     (rstn),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.bus      (xfer.link)
	);

	// ==========================================================
	// pulse measurement and dimming generator
	dimming_duty_unit #(
		.WIN_BITS (WIN_BITS),
		.DIM_DIV  (DIM_DIV)
	) u_duty (
		.sys_clk       (sys_clk),
		.rstn          (rstn),
		.pulse_pin     (dimming_pulse_input),
		.enable        (q.bl_state),
		.duty_in       (q.duty),
		.measured_duty (measured),
		.dim_pulse     (internal_dimming_pulse)
	);

	// ==========================================================
	// read views of the read-only registers
	always_comb begin
		ovc    = q.pin_s2[PIN_OVERCURRENT];
		conv   = q.pin_s2[PIN_CONV_FAULT];
		nfault = count_faults(q.pin_s2[NPIN-1:PIN_CHAN0]);
		status_w = STATUS_RST;                                    // bits 7:6 stay zero
		status_w[5] = (nfault >= 8'h2);
		status_w[4] = (nfault == 8'h1);
		status_w[3] = q.bl_state;
		status_w[2] = ovc;
		status_w[1] = q.thermal;
		status_w[0] = q.thermal | ovc | conv;                     // string faults left out
		ident_w = {1'h1, MAKER_CODE, REVISION};                   // fixed, no write path
	end

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.pin_s1 = {led_channel_fault, conv_pin_vec()};
		d.pin_s2 = q.pin_s1;
		d.req_s1 = xfer.req_tgl;
		d.req_s2 = q.req_s1;
		d.req_s3 = q.req_s2;
		req_ev = q.req_s2 ^ q.req_s3;
		// bus access: words are stable once the toggle is seen
		if (req_ev) begin
			d.ack_tgl = ~q.ack_tgl;
			if (xfer.we) begin
				case (xfer.addr)
					REG_BRIGHTNESS: if (!q.ctrl[CTL_SRC_BIT])
						d.bright = xfer.wdata;                           // dropped in pulse mode
					REG_CONTROL: d.ctrl = xfer.wdata[2:0];             // upper bits discarded
					default: ;                                          // status, ident, unmapped ignore writes
				endcase
			end else begin
				case (xfer.addr)
					REG_BRIGHTNESS: d.rdata = q.ctrl[CTL_SRC_BIT] ? measured : q.bright;
					REG_CONTROL: d.rdata = {5'h0, q.ctrl};
					REG_STATUS: d.rdata = status_w;
					REG_IDENT: d.rdata = ident_w;
					default: d.rdata = 8'h00;                           // unmapped reads zero
				endcase
			end
		end
		// thermal latch: over-temperature wins over a simultaneous release
		d.thermal = q.pin_s2[PIN_OVER_TEMP] | (q.thermal & ~q.pin_s2[PIN_TEMP_REL]);
		d.ctrl_en = q.ctrl[CTL_ON_BIT] & ~q.thermal;
		// soft start; any off request or thermal event drops it at once
		if (!q.ctrl[CTL_ON_BIT] || q.thermal) begin
			d.bl_state = 1'h0;
			d.on_cnt = 20'h0;
		end else if (!q.bl_state) begin
			if (q.on_cnt == ON_LAST)
				d.bl_state = 1'h1;                                    // on within the limit
			else
				d.on_cnt = q.on_cnt + 20'h1;
		end
		// brightness multiplexer
		if (q.ctrl[CTL_SRC_BIT])
			d.duty = measured;
		else if (q.ctrl[CTL_MD_BIT])
			d.duty = q.bright;
		else
			d.duty = scale_duty(q.bright, measured);
	end

	// the four scalar fault pins in their vector order
	function automatic logic [3:0] conv_pin_vec();
		return {converter_fault, input_overcurrent, temp_release, over_temp};
	endfunction : conv_pin_vec

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= '{bright: BRIGHTNESS_RST, ctrl: CONTROL_RST, duty: DUTY_RST, default: '0};
		else
			q <= d;
	end

	// ==========================================================
	// outputs
	assign xfer.ack_tgl      = q.ack_tgl;
	assign xfer.rdata        = q.rdata;
	assign controller_enable = q.ctrl_en;
	assign led_enable        = q.bl_state;
	assign duty_level        = q.duty;
endmodule : backlight_dimming_control_status_regs

// [design/backlight_pkg.sv]
package backlight_pkg;
	// ==========================================================
	// bus addressing
	localparam logic [6:0] TARGET_ADDR     = 7'h2c;   // 0b0101100
	localparam logic [7:0] REG_BRIGHTNESS  = 8'h00;
	localparam logic [7:0] REG_CONTROL     = 8'h01;
	localparam logic [7:0] REG_STATUS      = 8'h02;
	localparam logic [7:0] REG_IDENT       = 8'h03;
	// ==========================================================
	// field positions
	localparam int CTL_ON_BIT  = 0;                   // backlight_on_control
	localparam int CTL_SRC_BIT = 1;                   // brightness-source select
	localparam int CTL_MD_BIT  = 2;                   // input_interpretation_select
	localparam int IDENT_PANEL_BIT = 7;
	// ==========================================================
	// values after reset
	localparam logic [7:0] BRIGHTNESS_RST  = 8'hff;
	localparam logic [2:0] CONTROL_RST     = 3'h0;
	localparam logic [7:0] STATUS_RST      = 8'h00;
	localparam logic [7:0] DUTY_RST        = 8'hff;   // pulse duty starts at full scale
	// ==========================================================
	// fault pin positions inside the synchronised pin vector
	localparam int PIN_OVER_TEMP   = 0;
	localparam int PIN_TEMP_REL    = 1;
	localparam int PIN_OVERCURRENT = 2;
	localparam int PIN_CONV_FAULT  = 3;
	localparam int PIN_CHAN0       = 4;
	// ==========================================================
	// timing
	localparam longint SYS_CLK_HZ  = 100_000_000;
	localparam longint ON_TIME_MS  = 10;              // longest turn-on time
	localparam int ON_CYCLES       = int'((ON_TIME_MS * SYS_CLK_HZ) / 1000);
	// ==========================================================
	// link engine states
	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_CMD, LK_CMD_ACK,
		LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RD_ACK
	} link_state_type;
endpackage : backlight_pkg

// [design/dimming_duty_unit.sv]
`timescale 1ns/10ps
// ==========================================================
// pulse input duty measurement and internal dimming pulse
module dimming_duty_unit
	import backlight_pkg::*;
#(
	parameter int WIN_BITS = 20,          // measurement window is 2**WIN_BITS cycles
	parameter int DIM_DIV  = 391          // prescale of the 8-bit dimming counter
) (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       pulse_pin,
	input  wire logic       enable,
	input  wire logic [7:0] duty_in,
	output logic [7:0]      measured_duty,
	output logic            dim_pulse
);
	initial begin
		if (WIN_BITS < 8 || WIN_BITS > 30 || DIM_DIV < 1 || DIM_DIV > 65535)
			$error("dimming_duty_unit: unsupported parameters");
	end
	localparam logic [15:0] DIV_LAST = 16'(DIM_DIV - 1);
	typedef struct packed {
		logic                pin_s1, pin_s2;   // synchroniser
		logic [WIN_BITS-1:0] win, hi;          // window position, high samples
		logic [7:0]          meas;
		logic [15:0]         div;
		logic [7:0]          ramp;
		logic                pulse;
	} state_type;
	state_type q, d;

	// ==========================================================
	// averaging over a long window avoids a divider; the cost is a slow update
	always_comb begin
		d = q;
		d.pin_s1 = pulse_pin;
		d.pin_s2 = q.pin_s1;
		d.win = q.win + 1'b1;
		if (&q.win) begin                    // last sample skipped so all-high gives 0xff
			d.meas = q.hi[WIN_BITS-1 -: 8];
			d.hi = '0;
		end else begin
			d.hi = q.hi + WIN_BITS'(q.pin_s2);
		end
		d.div = (q.div == DIV_LAST) ? 16'h0 : q.div + 16'h1;
		if (q.div == DIV_LAST)
			d.ramp = q.ramp + 8'h1;
		d.pulse = enable & ((q.ramp < duty_in) | (&duty_in));
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= '{meas: DUTY_RST, default: '0};
		else
			q <= d;
	end

	assign measured_duty = q.meas;
	assign dim_pulse     = q.pulse;
endmodule : dimming_duty_unit

// [design/reg_xfer_if.sv]
`timescale 1ns/10ps
// ==========================================================
// register transfer between link engine and register bank
interface reg_xfer_if;
	logic       req_tgl;   // flips once per request (link domain)
	logic       we;        // request is a write
	logic [7:0] addr;      // register offset
	logic [7:0] wdata;     // write data
	logic       ack_tgl;   // flips once per answer (system domain)
	logic [7:0] rdata;     // read answer, loaded on the same clock edge as ack flips
	modport link (output req_tgl, output we, output addr, output wdata, input ack_tgl, input rdata);
	modport regs (input req_tgl, input we, input addr, input wdata, output ack_tgl, output rdata);
endinterface : reg_xfer_if

// [design/smbus_link_engine.sv]
`timescale 1ns/10ps
// ==========================================================
// two-wire target engine, runs on the link clock
module smbus_link_engine
	import backlight_pkg::*;
(
	input  wire logic link_clk,
	input  wire logic rstn,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	reg_xfer_if.link  bus
);
	typedef struct packed {
		logic           scl_s1, scl_s2, scl_s3;   // scl synchroniser and history
		logic           sda_s1, sda_s2, sda_s3;   // sda synchroniser and history
		logic           ack_s1, ack_s2, ack_s3;   // answer toggle crossing
		link_state_type st;
		logic [7:0]     sh;                       // shift register
		logic [3:0]     cnt;                      // bits seen in this byte
		logic           drv;                      // pulling sda low
		logic           req_tgl, we;
		logic [7:0]     cmd, wdata, tx;
	} state_type;
	state_type q, d;
	logic rise, fall, start, stop;
	logic [7:0] tx_now;

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.scl_s1 = scl_in;
		d.scl_s2 = q.scl_s1;
		d.scl_s3 = q.scl_s2;
		d.sda_s1 = sda_in;
		d.sda_s2 = q.sda_s1;
		d.sda_s3 = q.sda_s2;
		d.ack_s1 = bus.ack_tgl;
		d.ack_s2 = q.ack_s1;
		d.ack_s3 = q.ack_s2;
		rise  = q.scl_s2 & ~q.scl_s3;
		fall  = ~q.scl_s2 & q.scl_s3;
		start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
		stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
		// answer arrives well inside half a bit time; take it as it lands
		tx_now = (q.ack_s2 ^ q.ack_s3) ? bus.rdata : q.tx;
		d.tx = tx_now;
		if (start) begin                                        // repeated start resyncs too
			d.st = LK_ADDR;
			d.cnt = 4'h0;
			d.drv = 1'h0;
		end else if (stop) begin
			d.st = LK_IDLE;
			d.drv = 1'h0;
		end else if (rise) begin
			case (q.st)
				LK_ADDR, LK_CMD, LK_WDATA: begin
					d.sh = {q.sh[6:0], q.sda_s2};
					d.cnt = q.cnt + 4'h1;
				end
				LK_RDATA: d.cnt = q.cnt + 4'h1;
				LK_RD_ACK: begin
					d.sh[0] = q.sda_s2;                             // host ack, low = more
					if (!q.sda_s2) begin
						d.req_tgl = ~q.req_tgl;
						d.we = 1'h0;
					end
				end
				default: ;
			endcase
		end else if (fall) begin
			case (q.st)
				LK_ADDR: if (q.cnt == 4'h8) begin
					d.cnt = 4'h0;
					if (q.sh[7:1] == TARGET_ADDR) begin
						d.drv = 1'h1;
						d.st = LK_ADDR_ACK;
						d.sh[0] = q.sh[0];
						if (q.sh[0]) begin                          // read: fetch now
							d.req_tgl = ~q.req_tgl;
							d.we = 1'h0;
						end
					end else begin
						d.st = LK_IDLE;                             // not ours, stay silent
					end
				end
				LK_ADDR_ACK: begin
					if (q.sh[0]) begin
						d.st = LK_RDATA;
						d.sh = tx_now;
						d.drv = ~tx_now[7];
					end else begin
						d.st = LK_CMD;
						d.drv = 1'h0;
					end
				end
				LK_CMD: if (q.cnt == 4'h8) begin
					d.cmd = q.sh;
					d.cnt = 4'h0;
					d.drv = 1'h1;
					d.st = LK_CMD_ACK;
				end
				LK_WDATA: if (q.cnt == 4'h8) begin
					d.wdata = q.sh;
					d.we = 1'h1;
					d.req_tgl = ~q.req_tgl;
					d.cnt = 4'h0;
					d.drv = 1'h1;
					d.st = LK_WDATA_ACK;
				end
				LK_CMD_ACK, LK_WDATA_ACK: begin
					d.drv = 1'h0;
					d.st = LK_WDATA;
				end
				LK_RDATA: begin
					if (q.cnt == 4'h8) begin
						d.drv = 1'h0;
						d.cnt = 4'h0;
						d.st = LK_RD_ACK;
					end else begin
						d.drv = ~q.sh[6];
						d.sh = {q.sh[6:0], 1'h0};
					end
				end
				LK_RD_ACK: begin
					if (!q.sh[0]) begin
						d.st = LK_RDATA;
						d.sh = tx_now;
						d.drv = ~tx_now[7];
					end else begin
						d.st = LK_IDLE;                             // host nack ends the read
					end
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '{st: LK_IDLE, scl_s1: 1'h1, scl_s2: 1'h1, scl_s3: 1'h1, sda_s1: 1'h1, sda_s2: 1'h1,
			       sda_s3: 1'h1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign sda_out     = 1'h0;            // open drain: only ever pulls low
	assign sda_oe      = q.drv;
	assign bus.req_tgl = q.req_tgl;
	assign bus.we      = q.we;
	assign bus.addr    = q.cmd;
	assign bus.wdata   = q.wdata;
endmodule : smbus_link_engine

// [sim/backlight_dimming_control_status_regs_tb_top.sv]
`timescale 1ns/10ps
// ==========
// self-checking bench for the backlight register bank
module backlight_dimming_control_status_regs_tb_top import backlight_pkg::*;;
	localparam logic [3:0] MAKER  = 4'h5;  // arbitrary value
	localparam logic [2:0] REV    = 3'h6;  // arbitrary value
	localparam logic [7:0] ID_EXP = {1'b1, MAKER, REV};
	typedef struct packed {
		logic [7:0] brightness_level, ctl, duty, ctl_rd, brt_rd;
	} row_type;
	// brightness written, control written, duty, control read, brightness read
	row_type rows [5] = '{'{8'hff, 8'hfd, 8'hff, 8'h05, 8'hff}, '{8'h40, 8'h00, 8'h20, 8'h00, 8'h40},
		'{8'h33, 8'h06, 8'h80, 8'h06, 8'h80}, '{8'h11, 8'h02, 8'h80, 8'h02, 8'h80},
		'{8'h22, 8'h05, 8'h33, 8'h05, 8'h33}};
	logic [9:0] flt [4] = '{10'h001, 10'h081, 10'h200, 10'h1ff};  // {ovc, conv, channels}
	logic       sys_clk, link_clk, rstn, scl, host_low, pulse, hot, cool, ovc, conv, ok;
	logic       sda_out, sda_oe, ctl_en, led_en, dim;
	logic [7:0] chf, duty, d, exp_st;
	logic [8:0] k;
	wire        sda = ~sda_oe & ~host_low;  // pulled-up wire
	int         n_mismatch, checks_done;
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// unrelated phase to the system clock
	initial begin
		link_clk = 0;
		#3;
		forever #16 link_clk = ~link_clk;
	end
	// half-duty pulse, period 8 cycles, reads as 0x80
	initial begin
		pulse = 0;
		forever #40 pulse = ~pulse;
	end
	backlight_dimming_control_status_regs #(
		.ON_DELAY_CYCLES(20), .WIN_BITS(8), .DIM_DIV(1), .MAKER_CODE(MAKER), .REVISION(REV)
	) uut (
		.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .dimming_pulse_input(pulse), .over_temp(hot),
		.temp_release(cool), .input_overcurrent(ovc), .converter_fault(conv),
		.led_channel_fault(chf), .controller_enable(ctl_en), .led_enable(led_en),
		.internal_dimming_pulse(dim), .duty_level(duty)
	);
	smbus_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(host_low));
	// ==========
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rdchk(input string nm, input logic [7:0] adr, input logic [7:0] exp);
		logic [7:0] v;
		logic       a;
		host.rd(TARGET_ADDR, adr, v, a);
		chk({nm, " ack"}, 8'h01, {7'h0, a});
		chk(nm, exp, v);
	endtask : rdchk
	task automatic wrreg(input logic [7:0] adr, input logic [7:0] dat);
		logic a;
		host.wr(TARGET_ADDR, adr, dat, a);
		chk("write ack", 8'h01, {7'h0, a});
	endtask : wrreg
	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// hang guard, some margin over the expected run of about 70k cycles
	initial begin
		#900_000;
		n_mismatch++;
		stop_test();
	end
	// ==========
	// main sequence
	initial begin
		{rstn, hot, cool, ovc, conv, chf} = '0;
		cyc(3);
		rstn = 1;
		cyc(5);
		chk("reset duty", 8'hff, duty);
		rdchk("status", REG_STATUS, STATUS_RST);
		rdchk("ident", REG_IDENT, ID_EXP);
		rdchk("control", REG_CONTROL, 8'h00);
		rdchk("brightness", REG_BRIGHTNESS, 8'hff);
		wrreg(REG_IDENT, 8'h00);
		wrreg(REG_STATUS, 8'hff);
		rdchk("ident kept", REG_IDENT, ID_EXP);
		rdchk("status kept", REG_STATUS, 8'h00);
		rdchk("unmapped", 8'h07, 8'h00);
		host.rd(7'h2d, REG_IDENT, d, ok);
		chk("foreign ack", 8'h00, {7'h0, ok});
		// brightness first, so later rows hit pulse mode
		foreach (rows[i]) begin
			wrreg(REG_BRIGHTNESS, rows[i].brightness_level);
			wrreg(REG_CONTROL, rows[i].ctl);
			rdchk("control", REG_CONTROL, rows[i].ctl_rd);
			rdchk("brightness", REG_BRIGHTNESS, rows[i].brt_rd);
			chk("duty", rows[i].duty, duty);
		end
		// duty 0x33 gives 51 of 256 cycles high
		k = '0;
		repeat (256) begin
			cyc(1);
			k = k + {8'h0, dim};
		end
		chk("pulse highs", 8'h33, k[7:0]);
		foreach (flt[i]) begin
			{ovc, conv, chf} = flt[i];
			cyc(8);
			exp_st = {2'b0, $countones(chf) > 1, $countones(chf) == 1, 1'b1, ovc, 1'b0, ovc | conv};
			rdchk("faults", REG_STATUS, exp_st);
		end
		{ovc, conv, chf} = '0;
		hot = 1;
		cyc(10);
		chk("hot enables", 8'h00, {6'h0, ctl_en, led_en});
		hot = 0;
		cyc(10);
		rdchk("hot status", REG_STATUS, 8'h03);
		chk("latched enables", 8'h00, {6'h0, ctl_en, led_en});
		cool = 1;
		cyc(10);
		cool = 0;
		cyc(30);
		chk("cool enables", 8'h03, {6'h0, ctl_en, led_en});
		rdchk("cool status", REG_STATUS, 8'h08);
		wrreg(REG_CONTROL, 8'h00);
		chk("off enables", 8'h00, {6'h0, ctl_en, led_en});
		chk("sda_out", 8'h00, {7'h0, sda_out});
		stop_test();
	end
endmodule : backlight_dimming_control_status_regs_tb_top

// [sim/backlight_monitor.sv]
`timescale 1ns/10ps
// ==========
// port-level checks on the backlight register bank
module backlight_monitor #(
	parameter int ON_DELAY_CYCLES = 20  // soft start length
) (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       link_clk,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic       over_temp,
	input wire logic       temp_release,
	input wire logic       controller_enable,
	input wire logic       led_enable,
	input wire logic       internal_dimming_pulse,
	input wire logic [7:0] duty_level
);
	int on_cnt_q;  // cycles the controller has been on
	// saturating count, so the upper check fires once per turn-on
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) on_cnt_q <= 0;
		else if (!controller_enable) on_cnt_q <= 0;
		else if (on_cnt_q < ON_DELAY_CYCLES + 8) on_cnt_q <= on_cnt_q + 1;
	end
	// ==========
	// hot then cooling, with no release seen yet
	sequence s_cooling;
		$fell(over_temp) ##0 (!temp_release) [*8];
	endsequence
	property p_reset;
		@(posedge sys_clk) disable iff (!rstn) $rose(rstn) |-> duty_level == 8'hff && !controller_enable && !led_enable;
	endproperty
	property p_off;
		@(posedge sys_clk) disable iff (!rstn) (!controller_enable) [*3] |-> !led_enable;
	endproperty
	property p_on_win;
		@(posedge sys_clk) disable iff (!rstn)
			$rose(led_enable) |-> on_cnt_q inside {[ON_DELAY_CYCLES-2:ON_DELAY_CYCLES+3]};
	endproperty
	property p_on_max;
		@(posedge sys_clk) disable iff (!rstn) on_cnt_q == ON_DELAY_CYCLES + 4 |-> led_enable;
	endproperty
	property p_hot;
		@(posedge sys_clk) disable iff (!rstn) $rose(over_temp) |-> ##[1:8] (!controller_enable && !led_enable);
	endproperty
	property p_hold;
		@(posedge sys_clk) disable iff (!rstn) s_cooling |-> !controller_enable && !led_enable;
	endproperty
	property p_dark;
		@(posedge sys_clk) disable iff (!rstn) (!led_enable) [*2] |-> !internal_dimming_pulse;
	endproperty
	property p_full;
		@(posedge sys_clk) disable iff (!rstn) (led_enable && duty_level == 8'hff) [*2] |-> internal_dimming_pulse;
	endproperty
	property p_oe;
		@(posedge link_clk) disable iff (!rstn) scl_in && $past(scl_in) |-> $stable(sda_oe);
	endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");
	a_off: assert property (p_off) else $error("backlight on with controller off");
	a_on_win: assert property (p_on_win) else $error("turn-on at wrong time");
	a_on_max: assert property (p_on_max) else $error("turn-on too late");
	a_hot: assert property (p_hot) else $error("no shutdown when hot");
	a_hold: assert property (p_hold) else $error("restart before release");
	a_dark: assert property (p_dark) else $error("pulse while off");
	a_full: assert property (p_full) else $error("full duty not steady");
	a_oe: assert property (p_oe) else $error("data moved while clock high");
endmodule : backlight_monitor

bind backlight_dimming_control_status_regs backlight_monitor #(.ON_DELAY_CYCLES(ON_DELAY_CYCLES)) u_monitor (
	.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl_in), .sda_oe(sda_oe),
	.over_temp(over_temp), .temp_release(temp_release), .controller_enable(controller_enable),
	.led_enable(led_enable), .internal_dimming_pulse(internal_dimming_pulse), .duty_level(duty_level)
);

// [sim/smbus_host_model.sv]
`timescale 1ns/10ps
// ==========
// bit-banged two-wire host, open drain on data
module smbus_host_model (
	input  wire logic sys_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	localparam int HALF = 25;  // half bit, far above the target sync delay
	// idle: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	// data moves a little after the clock falls, never while high
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_low = ~b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		r = sda;
		scl = 1'b0;
	endtask : bit_io
	// start and repeated start alike
	task automatic start;
		sda_low = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_low = 1'b1;
		tick(HALF);
		scl = 1'b0;
	endtask : start
	task automatic stop;
		tick(2);
		sda_low = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_low = 1'b0;
		tick(HALF);
	endtask : stop
	// msb first, ninth bit is the acknowledge
	task automatic byte_io(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(nack, r);
		ack = ~r;
	endtask : byte_io
	task automatic wr(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] dat, output logic ok);
		logic [7:0] rx;
		logic       a;
		start();
		byte_io({dev, 1'b0}, 1'b1, rx, ok);
		byte_io(adr, 1'b1, rx, a);
		byte_io(dat, 1'b1, rx, a);
		stop();
	endtask : wr
	// nack on the one data byte ends the read
	task automatic rd(input logic [6:0] dev, input logic [7:0] adr, output logic [7:0] dat, output logic ok);
		logic [7:0] rx;
		logic       a;
		start();
		byte_io({dev, 1'b0}, 1'b1, rx, ok);
		byte_io(adr, 1'b1, rx, a);
		start();
		byte_io({dev, 1'b1}, 1'b1, rx, a);
		byte_io(8'hff, 1'b1, dat, a);
		stop();
	endtask : rd
endmodule : smbus_host_model
